/* hdl/spas_pkg.sv */
// constants, register map and types of the servo power and alarm sequencer
package spas_pkg;
  // time base
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PROTECT_DELAY_MS = 1500;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] OFS_PWR_WAIT  = 8'h10;
  localparam logic [7:0] OFS_RUN_BRK   = 8'h14;
  localparam logic [7:0] OFS_REL_SPEED = 8'h18;
  localparam logic [7:0] OFS_STALL_BRK = 8'h1C;
  localparam logic [7:0] OFS_STOP_TIME = 8'h20;
  localparam logic [7:0] OFS_CLR_TIME  = 8'h24;
  localparam logic [7:0] OFS_SCALE_POS = 8'h28;
  // field positions
  localparam int unsigned CTRL_DB_BIT    = 0;
  localparam int unsigned CTRL_ABS_BIT   = 1;
  localparam int unsigned IRQ_ALARM_BIT  = 0;
  localparam int unsigned IRQ_CLEAR_BIT  = 1;
  localparam int unsigned IRQ_PROT_BIT   = 2;
  localparam int unsigned IRQ_W          = 3;
  // reset values, times in ms, speed in r/min
  localparam logic [15:0] RST_PWR_WAIT  = 16'(PROTECT_DELAY_MS);
  localparam logic [15:0] RST_RUN_BRK   = 16'h0032;
  localparam logic [15:0] RST_REL_SPEED = 16'h001E;
  localparam logic [15:0] RST_STALL_BRK = 16'h0000;
  localparam logic [15:0] RST_STOP_TIME = 16'h0032;
  localparam logic [15:0] RST_CLR_TIME  = 16'h0078;
  localparam logic [1:0]  RST_CTRL      = 2'h0;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_READY = 3'b001,
    ST_RUN   = 3'b010,
    ST_ALARM = 3'b011,
    ST_OFF   = 3'b100
  } spas_state_t;

  typedef struct packed {
    logic [15:0] pwr_wait;
    logic [15:0] run_brk;
    logic [15:0] rel_speed;
    logic [15:0] stall_brk;
    logic [15:0] stop_time;
    logic [15:0] clr_time;
  } spas_cfg_t;
endpackage : spas_pkg

/* hdl/spas_sync.sv */
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module spas_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i, // system clock
  input  wire logic         rst_i, // synchronous reset
  input  wire logic [W-1:0] d_i,   // asynchronous inputs
  output logic      [W-1:0] q_o    // synchronised levels
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_r[i] <= 1'b0;
        q_o[i]    <= 1'b0;
      end else begin
        meta_r[i] <= d_i[i];
        q_o[i]    <= meta_r[i];
      end
    end
  end
endmodule : spas_sync
`default_nettype wire

/* hdl/spas_tick.sv */
// millisecond tick generator
`timescale 1ns/1ps
`default_nettype none
module spas_tick #(
  parameter int unsigned CYCLES = 100000
) (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // synchronous reset
  output logic      tick_o  // one-cycle pulse per period
);
  logic [31:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_r == 32'(CYCLES - 1)) begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : spas_tick
`default_nettype wire

/* hdl/spas_top.sv */
// servo power-up and alarm sequencer with wishbone registers
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module spas_top
  import spas_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic        clk_i,               // 100 MHz clock
  input  wire logic        rst_i,               // synchronous reset, high
  input  wire logic        wb_cyc_i,            // wishbone cycle
  input  wire logic        wb_stb_i,            // wishbone strobe
  input  wire logic        wb_we_i,             // wishbone write
  input  wire logic [7:0]  wb_adr_i,            // byte address
  input  wire logic [3:0]  wb_sel_i,            // byte enables
  input  wire logic [31:0] wb_dat_i,            // write data
  output logic      [31:0] wb_dat_o,            // read data
  output logic             wb_ack_o,            // acknowledge
  input  wire logic        init_done_i,         // processor initialisation done
  input  wire logic        alarm_event_i,       // protection fault detected
  input  wire logic [15:0] motor_speed_i,       // speed magnitude, r/min
  input  wire logic        main_power_i,        // main power present, pin
  input  wire logic        servo_on_input,      // servo-on request, pin
  input  wire logic        alarm_clear_input,   // alarm clear request, pin
  input  wire logic        scale_serial_line,   // serial scale data, pin
  input  wire logic        scale_phase_a,       // scale phase a, pin
  input  wire logic        scale_phase_b,       // scale phase b, pin
  input  wire logic        scale_index_phase,   // scale index, pin
  output logic             servo_ready_o,       // servo ready
  output logic             servo_on_status_output, // servo-on received
  output logic             cmd_accept_o,        // motion commands accepted
  output logic             protect_active_o,    // protection enabled
  output logic             alarm_o,             // alarm active
  output logic             brake_release_o,     // high keeps holding brake open
  output logic             dyn_brake_o,         // dynamic brake applied
  output logic             irq_o                // level interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and time base
  logic [6:0]  pins_s;
  logic        tick;
  logic        servo_on_input_s, clr_s, pwr_s, ser_s, pa_s, pb_s, pz_s;
  spas_sync #(.W(7)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scale_index_phase, scale_phase_b, scale_phase_a, scale_serial_line,
             main_power_i, alarm_clear_input, servo_on_input}),
    .q_o   (pins_s)
  );
  assign {pz_s, pb_s, pa_s, ser_s, pwr_s, clr_s, servo_on_input_s} = pins_s;
  spas_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  spas_cfg_t          cfg_r;
  logic [1:0]         ctrl_r;
  logic [IRQ_W-1:0]   irq_stat_r, irq_mask_r, irq_set;
  logic [31:0]        scale_pos_r, scale_shift_r;
  logic               pa_p_r, pb_p_r, pz_p_r;
  spas_state_t        state_r, state_nxt;
  logic               init_done_r, protect_r;
  logic [15:0]        init_ms_r, alarm_ms_r, clr_ms_r;
  logic               alarm_hit, speed_low, engage, clr_done;
  logic               wb_req, wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge that samples ack, the one edge at which the master takes the answer
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // byte-lane merge for 16-bit setting registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // initialisation and protection delay
  // protection delay counts from reset release, independent of processor progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_done_r <= 1'b0;
      init_ms_r   <= 16'h0;
      protect_r   <= 1'b0;
    end else begin
      if (init_done_i)
        init_done_r <= 1'b1;
      if (tick && init_ms_r != 16'hFFFF)
        init_ms_r <= init_ms_r + 16'h1;
      if (init_ms_r >= cfg_r.pwr_wait)
        protect_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  assign speed_low = motor_speed_i < cfg_r.rel_speed;
  assign alarm_hit = protect_r && alarm_event_i; // faults ignored before protection is live
  // brake engage: speed drop or delay, delay limited by the stop time when longer
  assign engage = speed_low ||
                  ((cfg_r.run_brk <= cfg_r.stop_time) ? (alarm_ms_r >= cfg_r.run_brk)
                                                      : (alarm_ms_r >= cfg_r.stop_time));
  assign clr_done = clr_s && (clr_ms_r >= cfg_r.clr_time);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        if (init_done_r)
          state_nxt = ST_READY; // servo-on held here has no effect
      end
      ST_READY: begin
        if (alarm_hit)
          state_nxt = ST_OFF;
        else if (servo_on_input_s && pwr_s)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (alarm_hit)
          state_nxt = speed_low ? ST_OFF : ST_ALARM; // stalled: zero brake delay
        else if (!servo_on_input_s || !pwr_s)
          state_nxt = ST_READY;
      end
      ST_ALARM: begin
        if (engage)
          state_nxt = ST_OFF;
      end
      ST_OFF: begin
        if (clr_done && !alarm_event_i)
          state_nxt = ST_READY;
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_r <= ST_INIT;
    else
      state_r <= state_nxt;
  end

  // time spent decelerating after the alarm
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != ST_ALARM)
      alarm_ms_r <= 16'h0;
    else if (tick && alarm_ms_r != 16'hFFFF)
      alarm_ms_r <= alarm_ms_r + 16'h1;
  end

  // alarm clear must be held without a break; any drop restarts the count
  always_ff @(posedge clk_i) begin
    if (rst_i || !clr_s)
      clr_ms_r <= 16'h0;
    else if (tick && clr_ms_r != 16'hFFFF)
      clr_ms_r <= clr_ms_r + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_ready_o          <= 1'b0;
      servo_on_status_output <= 1'b0;
      cmd_accept_o           <= 1'b0;
      protect_active_o       <= 1'b0;
      alarm_o                <= 1'b0;
      brake_release_o        <= 1'b0;
      dyn_brake_o            <= 1'b0;
    end else begin
      servo_ready_o          <= init_done_r && pwr_s;
      servo_on_status_output <= servo_on_input_s;
      cmd_accept_o           <= state_nxt == ST_RUN;
      protect_active_o       <= protect_r;
      alarm_o                <= state_nxt == ST_ALARM || state_nxt == ST_OFF;
      brake_release_o        <= state_nxt == ST_RUN || state_nxt == ST_ALARM;
      dyn_brake_o            <= (state_nxt == ST_ALARM || state_nxt == ST_OFF)
                                && ctrl_r[CTRL_DB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external scale: quadrature count or serial frame shifted on phase a
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_p_r        <= 1'b0;
      pb_p_r        <= 1'b0;
      pz_p_r        <= 1'b0;
      scale_pos_r   <= 32'h0;
      scale_shift_r <= 32'h0;
    end else begin
      pa_p_r <= pa_s;
      pb_p_r <= pb_s;
      pz_p_r <= pz_s;
      if (!ctrl_r[CTRL_ABS_BIT]) begin
        if ((pa_s ^ pa_p_r) || (pb_s ^ pb_p_r))
          scale_pos_r <= (pa_p_r ^ pb_s) ? scale_pos_r + 32'h1 : scale_pos_r - 32'h1;
      end else begin
        if (pa_s && !pa_p_r)
          scale_shift_r <= {scale_shift_r[30:0], ser_s};
        if (pz_s && !pz_p_r)
          scale_pos_r <= scale_shift_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one-to-clear
  assign irq_set = {protect_r && !protect_active_o,
                    state_r == ST_OFF && state_nxt == ST_READY,
                    state_r != ST_ALARM && state_r != ST_OFF &&
                    (state_nxt == ST_ALARM || state_nxt == ST_OFF)};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_o      <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0])
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r      <= '{RST_PWR_WAIT, RST_RUN_BRK, RST_REL_SPEED, RST_STALL_BRK,
                      RST_STOP_TIME, RST_CLR_TIME};
      ctrl_r     <= RST_CTRL;
      irq_mask_r <= '0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        OFS_CTRL:      if (wb_sel_i[0]) ctrl_r <= wb_dat_i[1:0];
        OFS_IRQ_MASK:  if (wb_sel_i[0]) irq_mask_r <= wb_dat_i[IRQ_W-1:0];
        OFS_PWR_WAIT:  cfg_r.pwr_wait  <= merge16(cfg_r.pwr_wait, wb_dat_i, wb_sel_i);
        OFS_RUN_BRK:   cfg_r.run_brk   <= merge16(cfg_r.run_brk, wb_dat_i, wb_sel_i);
        OFS_REL_SPEED: cfg_r.rel_speed <= merge16(cfg_r.rel_speed, wb_dat_i, wb_sel_i);
        OFS_STALL_BRK: cfg_r.stall_brk <= merge16(cfg_r.stall_brk, wb_dat_i, wb_sel_i);
        OFS_STOP_TIME: cfg_r.stop_time <= merge16(cfg_r.stop_time, wb_dat_i, wb_sel_i);
        OFS_CLR_TIME:  cfg_r.clr_time  <= merge16(cfg_r.clr_time, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero and are still acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          OFS_CTRL:      wb_dat_o <= {30'h0, ctrl_r};
          OFS_STATUS:    wb_dat_o <= {21'h0, state_r, 2'b00, dyn_brake_o, brake_release_o,
                                      alarm_o, protect_r, servo_on_status_output, servo_ready_o};
          OFS_IRQ_STAT:  wb_dat_o <= {29'h0, irq_stat_r};
          OFS_IRQ_MASK:  wb_dat_o <= {29'h0, irq_mask_r};
          OFS_PWR_WAIT:  wb_dat_o <= {16'h0, cfg_r.pwr_wait};
          OFS_RUN_BRK:   wb_dat_o <= {16'h0, cfg_r.run_brk};
          OFS_REL_SPEED: wb_dat_o <= {16'h0, cfg_r.rel_speed};
          OFS_STALL_BRK: wb_dat_o <= {16'h0, cfg_r.stall_brk};
          OFS_STOP_TIME: wb_dat_o <= {16'h0, cfg_r.stop_time};
          OFS_CLR_TIME:  wb_dat_o <= {16'h0, cfg_r.clr_time};
          OFS_SCALE_POS: wb_dat_o <= scale_pos_r;
          default:       wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_alarm_moving;
    state_r == ST_RUN && alarm_hit && !speed_low;
  endsequence
  sequence s_brake_open_alarm;
    state_r == ST_ALARM && brake_release_o;
  endsequence

  a_init_no_cmd: assert property (!init_done_r |=> !cmd_accept_o)
    else $error("command accepted during initialisation");
  a_ready_gate: assert property (servo_ready_o |-> $past(init_done_r) && $past(pwr_s))
    else $error("ready without init done and main power");
  a_protect_time: assert property ($rose(protect_r) |-> $past(init_ms_r) >= $past(cfg_r.pwr_wait))
    else $error("protection enabled before wait time");
  a_protect_early: assert property (!protect_r && state_r == ST_RUN |=> state_r != ST_ALARM)
    else $error("alarm taken before protection active");
  a_status_echo: assert property (servo_on_input_s ##1 servo_on_input_s |-> servo_on_status_output)
    else $error("servo-on status does not follow input");
  a_alarm_entry: assert property (s_run_alarm_moving |=> s_brake_open_alarm)
    else $error("brake not held open during alarm deceleration");
  a_speed_engage: assert property (state_r == ST_ALARM && speed_low |=> !brake_release_o)
    else $error("brake not engaged after speed drop");
  a_stall_zero: assert property (state_r == ST_RUN && alarm_hit && speed_low
                                 |=> !brake_release_o && state_r == ST_OFF)
    else $error("stalled alarm did not engage brake at once");
  a_db_select: assert property ((state_r == ST_OFF) ##1 (state_r == ST_OFF)
                                |-> dyn_brake_o == $past(ctrl_r[CTRL_DB_BIT]))
    else $error("dynamic brake differs from selection");
  a_short_delay: assert property (state_r == ST_ALARM && cfg_r.run_brk <= cfg_r.stop_time
                                  && alarm_ms_r >= cfg_r.run_brk |=> !brake_release_o)
    else $error("brake not engaged at running delay");
  a_long_delay: assert property (state_r == ST_ALARM && cfg_r.run_brk > cfg_r.stop_time
                                 && alarm_ms_r < cfg_r.stop_time && !speed_low |=> brake_release_o)
    else $error("brake engaged before off state");
  a_clear_hold: assert property (state_r == ST_OFF && state_nxt == ST_READY
                                 |-> clr_s && clr_ms_r >= cfg_r.clr_time)
    else $error("alarm cleared before recognition time");
  a_clear_break: assert property (state_r == ST_OFF && !clr_s && cfg_r.clr_time != 16'h0
                                  |=> state_r != ST_READY)
    else $error("alarm cleared without held input");
  a_scale_count: assert property (!ctrl_r[CTRL_ABS_BIT] && (pa_s != pa_p_r) && (pb_s == pb_p_r)
                                  |=> scale_pos_r != $past(scale_pos_r))
    else $error("incremental scale edge not counted");
endmodule : spas_top
`default_nettype wire

/* testbench/servo_power_alarm_sequencer_tb_top.sv */
// self-checking bench for the servo power and alarm sequencer
`timescale 1ns/1ps
`default_nettype none
module servo_power_alarm_sequencer_tb_top;
  import spas_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, init_done = 1'b0;
  logic alarm_ev = 1'b0, power = 1'b0, son_req = 1'b0, clr_go = 1'b0, son_pin, clr_pin;
  logic ready, son_st, accept, protect, alarm, brake, dyn, irq;
  logic pha = 1'b0, phb = 1'b0, ser = 1'b0, idx = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [15:0] speed = 16'h0000, clr_len = 16'h0000;
  int err_count = 0, total_checks = 0, cycle_cnt = 0;
  always #5 clk_i = ~clk_i;
  spas_host_model host (.clk_i(clk_i), .rst_i(rst_i), .son_req_i(son_req), .clr_go_i(clr_go),
    .clr_len_i(clr_len), .servo_on_o(son_pin), .alarm_clear_o(clr_pin));
  // short tick so that setting values count in 10-cycle units
  spas_top #(.TICK_CYC(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .init_done_i(init_done), .alarm_event_i(alarm_ev), .motor_speed_i(speed), .main_power_i(power),
    .servo_on_input(son_pin), .alarm_clear_input(clr_pin), .scale_serial_line(ser),
    .scale_phase_a(pha), .scale_phase_b(phb), .scale_index_phase(idx), .servo_ready_o(ready),
    .servo_on_status_output(son_st), .cmd_accept_o(accept), .protect_active_o(protect),
    .alarm_o(alarm), .brake_release_o(brake), .dyn_brake_o(dyn), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cw(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cw
  // one classic cycle; no fixed latency assumed, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) chk("ack", 32'h1, 32'h0);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic press(input logic [15:0] len);
    clr_len <= len; clr_go <= 1'b1;
    @(posedge clk_i);
    clr_go <= 1'b0;
  endtask : press
  task automatic fault;
    alarm_ev <= 1'b1;
    cw(2);
    alarm_ev <= 1'b0;
  endtask : fault
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up;
    son_req <= 1'b1;
    cw(8);
    chk("accept_in_init", 32'h0, {31'h0, accept});
    chk("status_in_init", 32'h1, {31'h0, son_st});
    init_done <= 1'b1;
    cw(8);
    chk("ready_no_power", 32'h0, {31'h0, ready});
    power <= 1'b1;
    cw(8);
    chk("ready", 32'h1, {31'h0, ready});
    chk("accept", 32'h1, {31'h0, accept});
  endtask : t_power_up
  task automatic t_setup;
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status_run", 32'h213, q);
    wb(1'b0, OFS_PWR_WAIT, 32'h0);
    chk("pwr_wait_rst", {16'h0, RST_PWR_WAIT}, q);
    wb(1'b0, OFS_CLR_TIME, 32'h0);
    chk("clr_time_rst", {16'h0, RST_CLR_TIME}, q);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, OFS_PWR_WAIT, 32'h28);
    wb(1'b1, OFS_CLR_TIME, 32'h4);
    wb(1'b1, OFS_IRQ_MASK, 32'h1);
    wb(1'b1, OFS_CTRL, 32'h1);
    fault();
    cw(4);
    chk("alarm_early", 32'h0, {31'h0, alarm});
    cw(250);
    chk("protect_early", 32'h0, {31'h0, protect});
    cw(150);
    chk("protect", 32'h1, {31'h0, protect});
  endtask : t_setup
  // short press must not clear, a full press must
  task automatic t_clear;
    press(16'h0014);
    cw(60);
    chk("alarm_short_press", 32'h1, {31'h0, alarm});
    press(16'h0050);
    cw(100);
    chk("alarm_cleared", 32'h0, {31'h0, alarm});
    chk("accept_after_clear", 32'h1, {31'h0, accept});
  endtask : t_clear
  task automatic t_run_alarm(input logic [31:0] run, input logic [31:0] stop, input logic drop);
    wb(1'b1, OFS_RUN_BRK, run);
    wb(1'b1, OFS_STOP_TIME, stop);
    speed <= 16'h03E8;
    cw(4);
    fault();
    cw(30);
    chk("alarm_run", 32'h1, {31'h0, alarm});
    chk("brake_open_decel", 32'h1, {31'h0, brake});
    chk("dyn_on", 32'h1, {31'h0, dyn});
    if (drop) speed <= 16'h0000;
    cw(50);
    chk("brake_engaged", 32'h0, {31'h0, brake});
    t_clear();
  endtask : t_run_alarm
  task automatic t_stall;
    wb(1'b1, OFS_CTRL, 32'h0);
    // earlier alarms, clears and protection start left all three flags set
    wb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat_all", 32'h7, q);
    wb(1'b1, OFS_IRQ_STAT, 32'h7);
    cw(2);
    chk("irq_idle", 32'h0, {31'h0, irq});
    speed <= 16'h0000;
    fault();
    cw(2);
    chk("brake_stall", 32'h0, {31'h0, brake});
    chk("dyn_off", 32'h0, {31'h0, dyn});
    chk("irq_up", 32'h1, {31'h0, irq});
    wb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat_alarm", 32'h1, q & 32'h1);
    wb(1'b1, OFS_IRQ_STAT, 32'h1);
    cw(3);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    t_clear();
  endtask : t_stall
  // one quadrature step, held long enough for the synchronisers
  task automatic qstep(input logic a, input logic b);
    pha <= a;
    phb <= b;
    cw(4);
  endtask : qstep
  // one count per edge, a unit ratio inside the recommended span
  task automatic t_scale;
    logic [3:0] frame;
    frame = 4'hB;
    qstep(1'b0, 1'b1);
    qstep(1'b1, 1'b1);
    qstep(1'b1, 1'b0);
    qstep(1'b0, 1'b0);
    qstep(1'b1, 1'b0);
    wb(1'b0, OFS_SCALE_POS, 32'h0);
    chk("scale_inc", 32'h3, q);
    wb(1'b1, OFS_CTRL, 32'h3);
    qstep(1'b0, 1'b0);
    // serial bits msb first, each shifted on a rising phase a
    for (int i = 3; i >= 0; i--) begin
      ser <= frame[i];
      cw(4);
      pha <= 1'b1;
      cw(4);
      pha <= 1'b0;
      cw(4);
    end
    idx <= 1'b1;
    cw(4);
    idx <= 1'b0;
    wb(1'b0, OFS_SCALE_POS, 32'h0);
    chk("scale_abs", 32'hB, q);
  endtask : t_scale
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, generous against roughly 1500 cycles of scenarios
  always @(posedge clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    cw(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_power_up();
    t_setup();
    t_run_alarm(32'h32, 32'h32, 1'b1);
    t_run_alarm(32'h5, 32'h32, 1'b0);
    t_run_alarm(32'h1E, 32'h5, 1'b0);
    t_scale();
    t_stall();
    tally_and_finish();
  end
endmodule : servo_power_alarm_sequencer_tb_top
`default_nettype wire

/* testbench/spas_host_model.sv */
// host controller model driving the servo-on and alarm-clear pins
`timescale 1ns/1ps
`default_nettype none
module spas_host_model (
  input  wire logic        clk_i,         // system clock
  input  wire logic        rst_i,         // synchronous reset
  input  wire logic        son_req_i,     // bench asks for servo-on
  input  wire logic        clr_go_i,      // start one alarm-clear press
  input  wire logic [15:0] clr_len_i,     // press length in cycles
  output logic             servo_on_o,    // servo-on pin
  output logic             alarm_clear_o  // alarm-clear pin
);
  logic [15:0] left_r;
  // servo-on level follows the request, changed only after an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) servo_on_o <= 1'b0;
    else servo_on_o <= son_req_i;
  end
  // a press is held unbroken for its count; a short count is an early release
  always_ff @(posedge clk_i) begin
    if (rst_i) left_r <= 16'h0000;
    else if (clr_go_i) left_r <= clr_len_i;
    else if (left_r != 16'h0000) left_r <= left_r - 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) alarm_clear_o <= 1'b0;
    else alarm_clear_o <= clr_go_i | (left_r > 16'h0001);
  end
endmodule : spas_host_model
`default_nettype wire
